// file: logic/tmw_timer.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module tmw_timer
	import tmw_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        EXT_COUNT_PIN,
	output logic             CMP_A_O,
	output logic             CMP_A_OE,
	output logic             CMP_B_O,
	output logic             CMP_B_OE,
	output logic             CAP_PIN_EN,
	output logic             IRQ
);
	import tmw_pkg::*;

	logic [7:0]  woc_r;
	logic [7:0]  stc_r;
	logic [15:0] cmpa_act_r;
	logic [15:0] cmpa_buf_r;
	logic [15:0] cmpb_act_r;
	logic [15:0] cmpb_buf_r;
	logic [15:0] cap_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        down_r;
	logic        down_nxt;
	logic [2:0]  stat_r;
	logic [2:0]  ien_r;
	logic [3:0]  pin_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire req_w  = WB_CYC_I & WB_STB_I;
	wire new_w  = req_w & ~ack_r;
	wire wr_w   = req_w & WB_WE_I & ack_r;
	wire wr_woc = wr_w & (WB_ADR_I == ADR_WOC);
	wire wr_stc = wr_w & (WB_ADR_I == ADR_STC);
	wire wr_ca  = wr_w & (WB_ADR_I == ADR_CMPA);
	wire wr_cb  = wr_w & (WB_ADR_I == ADR_CMPB);
	wire wr_cap = wr_w & (WB_ADR_I == ADR_CAP);
	wire wr_clr = wr_w & (WB_ADR_I == ADR_CLR) & WB_SEL_I[0];
	wire wr_ien = wr_w & (WB_ADR_I == ADR_IEN) & WB_SEL_I[0];
	wire wr_pin = wr_w & (WB_ADR_I == ADR_PIN) & WB_SEL_I[0];

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire [1:0]  act_a = woc_r[F_ACT_A +: 2];
	wire [1:0]  act_b = woc_r[F_ACT_B +: 2];
	wire [3:0]  mode  = {stc_r[F_WGM_HI +: 2], woc_r[F_WGM_LO +: 2]};
	wire [2:0]  cs    = stc_r[F_CS +: 3];
	wire tmw_class_t cls = mode_class(mode);
	wire top_cap = (mode == M_PFC_C) | (mode == M_PC_C) | (mode == M_CTC_C) | (mode == M_FP_C);
	wire top_ca  = (mode == M_PFC_A) | (mode == M_PC_A) | (mode == M_CTC_A) | (mode == M_FP_A);
	wire top8    = (mode == M_PC8) | (mode == M_FP8);
	wire top9    = (mode == M_PC9) | (mode == M_FP9);
	wire top10   = (mode == M_PC10) | (mode == M_FP10);
	wire [15:0] top_w = top_cap ? cap_r : top_ca ? cmpa_act_r : top8 ? TOP_8 :
		top9 ? TOP_9 : top10 ? TOP_10 : TOP_MAX;
	wire dual   = (cls == MC_PC) | (cls == MC_PFC);
	wire buffed = cls != MC_NONPWM;
	wire tog_a  = (cls == MC_FAST) ? (mode == M_FP_C | mode == M_FP_A) :
		(mode == M_PFC_A | mode == M_PC_A);

	// ------------------------------------------------------------
	// tick source
	// ------------------------------------------------------------
	logic tick;
	tmw_prescaler u_pre (
		.clk     (CLK),
		.rst_n   (RST_N),
		.sel     (cs),
		.ext_pin (EXT_COUNT_PIN),
		.tick    (tick)
	);

	// ------------------------------------------------------------
	// counter sequence
	// ------------------------------------------------------------
	wire at_top  = cnt_r >= top_w;
	wire at_bot  = cnt_r == RST_WORD;
	wire at_max  = cnt_r == TOP_MAX;
	// every count event below is gated by the tick enable
	wire wrap_s  = tick & ~dual & (cnt_r == top_w);
	wire fast_b  = tick & (cls == MC_FAST) & at_top;
	wire turn_t  = tick & dual & ~down_r & at_top;
	wire turn_b  = tick & dual & down_r & at_bot;
	wire upd_pt  = (cls == MC_FAST) ? fast_b : (cls == MC_PC) ? turn_t : turn_b;
	wire ovf_evt = (cls == MC_NONPWM) ? (tick & at_max) :
		(cls == MC_FAST) ? fast_b : turn_b;
	wire match_a = tick & (cnt_r == cmpa_act_r);
	wire match_b = tick & (cnt_r == cmpb_act_r);

	always_comb begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		if (tick) begin
			if (!dual) begin
				// a lowered top below the count in fast modes wraps at once
				cnt_nxt = (wrap_s || fast_b) ? RST_WORD : cnt_r + 16'h0001;
				down_nxt = 1'b0;
			end else if (!down_r) begin
				cnt_nxt  = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
				down_nxt = at_top;
			end else begin
				cnt_nxt  = at_bot ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
				down_nxt = ~at_bot;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cnt_r  <= RST_WORD;
			down_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			down_r <= down_nxt;
		end
	end

	// ------------------------------------------------------------
	// compare registers and buffers
	// ------------------------------------------------------------
	// immediate modes merge a partial write into the active value, not a stale buffer
	wire [15:0] ca_wr = merge16(buffed ? cmpa_buf_r : cmpa_act_r, WB_DAT_I, WB_SEL_I);
	wire [15:0] cb_wr = merge16(buffed ? cmpb_buf_r : cmpb_act_r, WB_DAT_I, WB_SEL_I);
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cmpa_buf_r <= RST_WORD;
			cmpb_buf_r <= RST_WORD;
		end else begin
			if (wr_ca) cmpa_buf_r <= ca_wr;
			if (wr_cb) cmpb_buf_r <= cb_wr;
		end
	end
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cmpa_act_r <= RST_WORD;
			cmpb_act_r <= RST_WORD;
		end else if (!buffed) begin
			if (wr_ca) cmpa_act_r <= ca_wr;
			if (wr_cb) cmpb_act_r <= cb_wr;
		end else if (upd_pt) begin
			cmpa_act_r <= cmpa_buf_r;
			cmpb_act_r <= cmpb_buf_r;
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			woc_r <= RST_BYTE;
			stc_r <= RST_BYTE;
			cap_r <= RST_WORD;
			pin_r <= '0;
			ien_r <= '0;
		end else begin
			if (wr_woc && WB_SEL_I[0]) woc_r <= WB_DAT_I[7:0] & WOC_MASK;
			if (wr_stc && WB_SEL_I[0]) stc_r <= WB_DAT_I[7:0] & STC_MASK;
			if (wr_cap) cap_r <= merge16(cap_r, WB_DAT_I, WB_SEL_I);
			if (wr_pin) pin_r <= WB_DAT_I[3:0];
			if (wr_ien) ien_r <= WB_DAT_I[2:0];
		end
	end

	// ------------------------------------------------------------
	// status and interrupt: a hardware set beats a clear in the same cycle
	// ------------------------------------------------------------
	wire [2:0] evt_w = {match_b, match_a, ovf_evt};
	wire [2:0] clr_w = wr_clr ? WB_DAT_I[2:0] : 3'h0;
	always_ff @(posedge CLK) begin
		if (!RST_N)
			stat_r <= '0;
		else
			stat_r <= (stat_r & ~clr_w) | evt_w;
	end
	assign IRQ = |(stat_r & ien_r);

	// ------------------------------------------------------------
	// compare output units
	// ------------------------------------------------------------
	logic oc_a;
	logic oc_b;
	tmw_out_unit u_oa (
		.clk        (CLK),
		.rst_n      (RST_N),
		.cls        (cls),
		.act        (act_a),
		.tog_ok     (tog_a),
		.match      (match_a),
		.cmp_is_top (cmpa_act_r == top_w),
		.bottom     (fast_b),
		.dir_down   (down_r),
		.ddr        (pin_r[P_DDR_A]),
		.port       (pin_r[P_PRT_A]),
		.oc         (oc_a),
		.pin_o      (CMP_A_O),
		.pin_oe     (CMP_A_OE)
	);
	// channel B never toggles in PWM modes
	tmw_out_unit u_ob (
		.clk        (CLK),
		.rst_n      (RST_N),
		.cls        (cls),
		.act        (act_b),
		.tog_ok     (1'b0),
		.match      (match_b),
		.cmp_is_top (cmpb_act_r == top_w),
		.bottom     (fast_b),
		.dir_down   (down_r),
		.ddr        (pin_r[P_DDR_B]),
		.port       (pin_r[P_PRT_B]),
		.oc         (oc_b),
		.pin_o      (CMP_B_O),
		.pin_oe     (CMP_B_OE)
	);

	assign CAP_PIN_EN = ~top_cap;

	// ------------------------------------------------------------
	// read path: one wait state, unmapped reads give zero
	// ------------------------------------------------------------
	always_comb begin
		case (WB_ADR_I)
			ADR_WOC:  rd_mux = {24'h0, woc_r};
			ADR_STC:  rd_mux = {24'h0, stc_r};
			ADR_CMPA: rd_mux = {16'h0, buffed ? cmpa_buf_r : cmpa_act_r};
			ADR_CMPB: rd_mux = {16'h0, buffed ? cmpb_buf_r : cmpb_act_r};
			ADR_CAP:  rd_mux = {16'h0, cap_r};
			ADR_CNT:  rd_mux = {16'h0, cnt_r};
			ADR_STAT: rd_mux = {29'h0, stat_r};
			ADR_IEN:  rd_mux = {29'h0, ien_r};
			ADR_PIN:  rd_mux = {28'h0, pin_r};
			default:  rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= new_w;
			if (new_w) dat_r <= rd_mux;
		end
	end
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	chk_count_tick_gated: assert property (
		cnt_r != $past(cnt_r) |-> $past(tick)) else $error("counter moved without tick");
	chk_pfc_bottom_load: assert property (
		cls == MC_PFC && tick && down_r && at_bot |=> cmpa_act_r == $past(cmpa_buf_r))
		else $error("pfc compare not loaded at bottom");
	chk_pc_no_bottom_load: assert property (
		cls == MC_PC && $past(cls) == MC_PC && cmpa_act_r != $past(cmpa_act_r) |-> $past(turn_t))
		else $error("phase correct compare loaded off top");
	chk_pin_port_own: assert property (
		act_a == 2'b00 |-> CMP_A_O == pin_r[P_PRT_A]) else $error("pin a not port bit");
	chk_driver_ddr_off: assert property (
		!pin_r[P_DDR_B] |-> !CMP_B_OE) else $error("driver on without direction");
	chk_nonpwm_toggle: assert property (
		cls == MC_NONPWM && act_a == 2'b01 && match_a |=> oc_a != $past(oc_a))
		else $error("non-pwm toggle missing");
	chk_fast_bottom_set: assert property (
		cls == MC_FAST && act_b == 2'b10 && fast_b |=> oc_b) else $error("fast pwm bottom set missing");
	chk_fast_top_ignore: assert property (
		cls == MC_FAST && act_a == 2'b11 && match_a && cmpa_act_r == top_w |=> !oc_a)
		else $error("fast pwm top match not ignored");
	chk_dual_down_set: assert property (
		dual && act_b == 2'b10 && match_b && down_r |=> oc_b) else $error("dual slope down set missing");
	chk_fast8_wrap: assert property (
		mode == M_FP8 && tick && cnt_r == TOP_8 |=> cnt_r == RST_WORD) else $error("8-bit fast wrap wrong");
	chk_pfc_ovf_flag: assert property (
		cls == MC_PFC && turn_b |=> stat_r[ST_OVF]) else $error("pfc overflow flag late");
	chk_cap_pin_off: assert property (
		top_cap |-> !CAP_PIN_EN) else $error("capture pin still connected");
	chk_ack_one_cycle: assert property (
		WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
	chk_fast_toggle_a: assert property (
		cls == MC_FAST && tog_a && act_a == 2'b01 && match_a |=> oc_a != $past(oc_a))
		else $error("fast pwm toggle missing");
	chk_b_pwm_port: assert property (
		cls != MC_NONPWM && act_b == 2'b01 |-> CMP_B_O == pin_r[P_PRT_B])
		else $error("pin b taken by pwm toggle");
	chk_tick_stopped: assert property (
		cs == CS_STOP |-> !tick) else $error("tick while stopped");
	chk_immediate_write: assert property (
		cls == MC_NONPWM && wr_ca |=> cmpa_act_r == $past(ca_wr))
		else $error("immediate compare write lost");

	cov_fast_wrap: cover property (cls == MC_FAST && fast_b);
	cov_pfc_bottom: cover property (cls == MC_PFC && turn_b);
	cov_chan_a_toggle: cover property (act_a == 2'b01 && match_a ##1 IRQ);
	cov_irq_raise: cover property (!IRQ ##1 IRQ);
	cov_dual_turn: cover property (dual && turn_t);
endmodule
`default_nettype wire

// file: pkg/tmw_pkg.sv
`default_nettype none
package tmw_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_WOC  = 8'h80;
	localparam logic [7:0] ADR_STC  = 8'h84;
	localparam logic [7:0] ADR_CMPA = 8'h88;
	localparam logic [7:0] ADR_CMPB = 8'h8c;
	localparam logic [7:0] ADR_CAP  = 8'h90;
	localparam logic [7:0] ADR_CNT  = 8'h94;
	localparam logic [7:0] ADR_STAT = 8'h98;
	localparam logic [7:0] ADR_CLR  = 8'h9c;
	localparam logic [7:0] ADR_IEN  = 8'ha0;
	localparam logic [7:0] ADR_PIN  = 8'ha4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int F_ACT_A  = 6;
	localparam int F_ACT_B  = 4;
	localparam int F_WGM_LO = 0;
	localparam int F_WGM_HI = 3;
	localparam int F_CS     = 0;
	localparam int ST_OVF   = 0;
	localparam int ST_MA    = 1;
	localparam int ST_MB    = 2;
	localparam int P_DDR_A  = 0;
	localparam int P_DDR_B  = 1;
	localparam int P_PRT_A  = 2;
	localparam int P_PRT_B  = 3;
	localparam logic [7:0] WOC_MASK = 8'hf3;
	localparam logic [7:0] STC_MASK = 8'h1f;
	// ------------------------------------------------------------
	// modes, tops, tick sources
	// ------------------------------------------------------------
	localparam logic [3:0] M_PC8 = 4'h1, M_PC9 = 4'h2, M_PC10 = 4'h3, M_CTC_A = 4'h4;
	localparam logic [3:0] M_FP8 = 4'h5, M_FP9 = 4'h6, M_FP10 = 4'h7, M_PFC_C = 4'h8;
	localparam logic [3:0] M_PFC_A = 4'h9, M_PC_C = 4'ha, M_PC_A = 4'hb, M_CTC_C = 4'hc;
	localparam logic [3:0] M_FP_C = 4'he, M_FP_A = 4'hf;
	localparam logic [15:0] TOP_MAX = 16'hffff, TOP_8 = 16'h00ff, TOP_9 = 16'h01ff, TOP_10 = 16'h03ff;
	localparam logic [2:0] CS_STOP = 3'h0, CS_D1 = 3'h1, CS_D8 = 3'h2, CS_D64 = 3'h3;
	localparam logic [2:0] CS_D256 = 3'h4, CS_D1024 = 3'h5, CS_FALL = 3'h6, CS_RISE = 3'h7;
	localparam logic [9:0] MSK_D8 = 10'h007, MSK_D64 = 10'h03f, MSK_D256 = 10'h0ff, MSK_D1024 = 10'h3ff;
	typedef enum logic [3:0] {
		MC_NONPWM = 4'b0001,
		MC_FAST   = 4'b0010,
		MC_PC     = 4'b0100,
		MC_PFC    = 4'b1000
	} tmw_class_t;
	function automatic tmw_class_t mode_class(input logic [3:0] m);
		case (m)
			M_PC8, M_PC9, M_PC10, M_PC_C, M_PC_A: mode_class = MC_PC;
			M_FP8, M_FP9, M_FP10, M_FP_C, M_FP_A: mode_class = MC_FAST;
			M_PFC_C, M_PFC_A:                     mode_class = MC_PFC;
			default:                              mode_class = MC_NONPWM;
		endcase
	endfunction
endpackage
`default_nettype wire

// file: logic/tmw_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module tmw_prescaler
	import tmw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] sel,
	input  wire logic       ext_pin,
	output logic            tick
);
	logic [9:0] div_r;
	logic [2:0] sync_r;
	logic       lvl_r;
	logic       lvl_old_r;
	logic       lvl_nxt;
	logic       rise_w;
	logic       fall_w;
	// ------------------------------------------------------------
	// external count pin: three stages, change taken once the last two stages agree
	// ------------------------------------------------------------
	assign lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
	assign rise_w  = lvl_r & ~lvl_old_r;
	assign fall_w  = ~lvl_r & lvl_old_r;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r     <= '0;
			sync_r    <= '0;
			lvl_r     <= 1'b0;
			lvl_old_r <= 1'b0;
		end else begin
			div_r     <= div_r + 10'h001;
			sync_r    <= {sync_r[1:0], ext_pin};
			lvl_r     <= lvl_nxt;
			lvl_old_r <= lvl_r;
		end
	end
	// the divider runs free, so the first tick after a select change may be early
	always_comb begin
		case (sel)
			CS_D1:    tick = 1'b1;
			CS_D8:    tick = (div_r & MSK_D8) == MSK_D8;
			CS_D64:   tick = (div_r & MSK_D64) == MSK_D64;
			CS_D256:  tick = (div_r & MSK_D256) == MSK_D256;
			CS_D1024: tick = (div_r & MSK_D1024) == MSK_D1024;
			CS_FALL:  tick = fall_w;
			CS_RISE:  tick = rise_w;
			default:  tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: logic/tmw_out_unit.sv
`timescale 1ns/1ns
`default_nettype none
module tmw_out_unit
	import tmw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire tmw_pkg::tmw_class_t cls,
	input  wire logic [1:0] act,
	input  wire logic       tog_ok,
	input  wire logic       match,
	input  wire logic       cmp_is_top,
	input  wire logic       bottom,
	input  wire logic       dir_down,
	input  wire logic       ddr,
	input  wire logic       port,
	output logic            oc,
	output logic            pin_o,
	output logic            pin_oe
);
	logic oc_r;
	logic oc_nxt;
	logic own_w;
	logic pwm_w;
	assign pwm_w = cls != MC_NONPWM;
	assign own_w = (act != 2'b00) && !(pwm_w && act == 2'b01 && !tog_ok);
	always_comb begin
		oc_nxt = oc_r;
		if (act == 2'b01 && match && (!pwm_w || tog_ok))
			oc_nxt = ~oc_r;
		else if (act[1]) begin
			case (cls)
				MC_NONPWM: if (match) oc_nxt = act[0];
				MC_FAST: begin
					// a match at top is dropped; the bottom action still runs
					if (match && !cmp_is_top) oc_nxt = act[0];
					if (bottom) oc_nxt = ~act[0];
				end
				MC_PC, MC_PFC: if (match) oc_nxt = dir_down ? ~act[0] : act[0];
				default: oc_nxt = oc_r;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			oc_r <= 1'b0;
		else
			oc_r <= oc_nxt;
	end
	assign oc     = oc_r;
	assign pin_o  = own_w ? oc_r : port;
	assign pin_oe = ddr;
endmodule
`default_nettype wire

// file: tb/test_timer16_waveform_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_timer16_waveform_mode_control;
	import tmw_pkg::*;
	typedef struct {logic [31:0] e; string n;} tmw_note_t;
	logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ext = 0;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] dat = 0, got = 0, rnd;
	logic [31:0] dat_o;
	logic        ack, a_o, a_oe, b_o, b_oe, cap_en, irq;
	int          mismatches = 0, num_checks = 0, ha, hb, ta;
	tmw_note_t   notes[$];
	event        probe;

	initial forever #20 clk = ~clk;

	tmw_timer u_tmw_timer (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.EXT_COUNT_PIN(ext), .CMP_A_O(a_o), .CMP_A_OE(a_oe), .CMP_B_O(b_o), .CMP_B_OE(b_oe),
		.CAP_PIN_EN(cap_en), .IRQ(irq));

	// ------------------------------------------------------------
	// result watching
	// ------------------------------------------------------------
	task end_of_test;
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input tmw_note_t nt);
		num_checks++;
		if (seen !== nt.e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nt.n, nt.e, seen);
		end
	endtask

	always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) check(dat_o, notes.pop_front());
	always @(probe) check(got, notes.pop_front());

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		// no cycle count assumed: ack ends this wait, the watchdog ends a hang
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		// let the write land before anyone samples the pins
		@(negedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		notes.push_back('{e, nm});
		wb(1'b0, a, 32'h0);
	endtask

	// wait for the next falling edge after each probe so the watcher sees every value
	task chk(input logic [31:0] g, input logic [31:0] e, input string nm);
		notes.push_back('{e, nm});
		got = g;
		->probe;
		@(negedge clk);
	endtask

	task mode(input logic [7:0] w, input logic [7:0] s);
		wr(ADR_WOC, w);
		wr(ADR_STC, s);
	endtask

	// settle first, then count high cycles and toggles over n cycles
	task run(input int settle, input int n);
		logic pa;
		repeat (settle) @(posedge clk);
		ha = 0;
		hb = 0;
		ta = 0;
		@(posedge clk);
		pa = a_o;
		repeat (n) begin
			@(posedge clk);
			ha += int'(a_o === 1'b1);
			hb += int'(b_o === 1'b1);
			ta += int'(a_o !== pa);
			pa = a_o;
		end
	endtask

	task pulses(input int n);
		@(posedge clk);
		repeat (n) begin
			ext <= 1'b1;
			repeat (10) @(posedge clk);
			ext <= 1'b0;
			repeat (10) @(posedge clk);
		end
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		end_of_test;
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		rnd = $urandom(32'hc1ef);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) rd(8'(8'h80 + 4 * i), 32'h0, "reset value");
		wr(ADR_WOC, 32'hff);
		rd(ADR_WOC, {24'h0, WOC_MASK}, "mode control");
		wr(ADR_STC, 32'hff);
		rd(ADR_STC, {24'h0, STC_MASK}, "second control");
		rnd = $urandom;
		wr(ADR_CAP, {16'h0, rnd[15:0]});
		rd(ADR_CAP, {16'h0, rnd[15:0]}, "capture value");
		wr(8'ha8, rnd);
		rd(8'ha8, 32'h0, "unmapped");
		for (int i = 0; i < 16; i++) begin
			mode({6'h0, i[1:0]}, {3'h0, i[3:2], 3'h0});
			chk(cap_en, (i inside {8, 10, 12, 14}) ? 32'h0 : 32'h1, "capture pin enable");
		end
		mode(8'h00, 8'h00);
		wr(ADR_PIN, 32'h04);
		chk({a_oe, a_o}, 32'h1, "pin a undriven");
		wr(ADR_PIN, 32'h0f);
		chk({a_oe, a_o, b_oe, b_o}, 32'hf, "pins driven");
		// compare-clear mode, top from compare a
		wr(ADR_CMPA, 32'h10);
		wr(ADR_CMPB, 32'h08);
		wr(ADR_PIN, 32'h0b);
		mode(8'he0, 8'h09);
		run(40, 32);
		chk(ha, 32, "set on match");
		chk(hb, 0, "clear on match");
		wr(ADR_WOC, 32'h40);
		run(4, 34);
		chk(ta, 2, "toggle on match");
		chk(hb, 34, "port bit b");
		// fast pwm 8 bit
		wr(ADR_PIN, 32'h0f);
		wr(ADR_CMPA, 32'h80);
		wr(ADR_CMPB, 32'hff);
		mode(8'hb1, 8'h09);
		run(300, 256);
		chk(ha, 129, "fast non-inverting");
		chk(hb, 0, "fast compare at top");
		wr(ADR_WOC, 32'he1);
		run(300, 256);
		chk(ha, 127, "fast inverting");
		chk(hb, 256, "fast compare at top inv");
		// buffered compare: stopped counter never reaches the update point
		wr(ADR_STC, 32'h08);
		wr(ADR_CMPA, 32'h20);
		rd(ADR_CMPA, 32'h20, "compare buffer");
		wr(ADR_WOC, 32'h00);
		rd(ADR_CMPA, 32'h80, "compare active held");
		mode(8'h01, 8'h09);
		run(300, 1);
		mode(8'h00, 8'h08);
		rd(ADR_CMPA, 32'h20, "compare loaded at bottom");
		wr(ADR_CMPA, 32'h80);
		wr(ADR_CMPB, 32'h80);
		// dual slope
		mode(8'hb1, 8'h01);
		run(600, 510);
		chk(ha, 256, "phase correct up clear");
		chk(hb, 254, "phase correct up set");
		wr(ADR_WOC, 32'h43);
		run(4, 64);
		chk(ha, 64, "no toggle in mode 3");
		mode(8'h51, 8'h11);
		run(600, 512);
		chk(ta, 2, "toggle in mode 9");
		chk(hb, 512, "b stays port bit");
		// fast pwm with top from compare a
		mode(8'h00, 8'h08);
		wr(ADR_CMPA, 32'h03);
		mode(8'h53, 8'h19);
		run(20, 64);
		chk(ta, 16, "toggle in mode 15");
		chk(hb, 64, "b stays port bit fast");
		mode(8'h51, 8'h09);
		run(4, 64);
		chk(ha, 64, "no toggle in mode 5");
		// pin-driven tick sources from a known zero count
		mode(8'h00, 8'h08);
		wr(ADR_CMPA, 32'h00);
		mode(8'h03, 8'h19);
		run(10, 1);
		// stop first: a mode change while ticking would move the count
		wr(ADR_STC, 32'h18);
		wr(ADR_WOC, 32'h00);
		rd(ADR_CNT, 32'h0, "count held at zero");
		wr(ADR_STC, 32'h07);
		pulses(5);
		rd(ADR_CNT, 32'h5, "rising pin count");
		wr(ADR_STC, 32'h06);
		pulses(3);
		rd(ADR_CNT, 32'h8, "falling pin count");
		wr(ADR_STC, 32'h00);
		pulses(2);
		rd(ADR_CNT, 32'h8, "stopped count");
		// prescaled ticks: top zero in mode 15, so channel a toggles once per tick
		mode(8'h43, 8'h1a);
		run(16, 16);
		chk(ta, 2, "divide by 8");
		wr(ADR_STC, 32'h1b);
		run(1, 128);
		chk(ta, 2, "divide by 64");
		wr(ADR_STC, 32'h1c);
		run(1, 512);
		chk(ta, 2, "divide by 256");
		wr(ADR_STC, 32'h1d);
		run(1, 2048);
		chk(ta, 2, "divide by 1024");
		mode(8'h00, 8'h00);
		// flags and interrupt
		wr(ADR_CMPA, 32'h10);
		wr(ADR_CLR, 32'h07);
		mode(8'h01, 8'h09);
		run(300, 1);
		chk(irq, 0, "masked irq");
		wr(ADR_STC, 32'h08);
		rd(ADR_STAT, 32'h7, "status flags");
		wr(ADR_IEN, 32'h01);
		chk(irq, 1, "enabled irq");
		wr(ADR_CLR, 32'h01);
		chk(irq, 0, "cleared irq");
		rd(ADR_STAT, 32'h6, "status after clear");
		end_of_test;
	end
endmodule
`default_nettype wire
